// >>> rtl/flash_read_pkg.sv
// How it works
// - continuous read mode exists only for quad reads EBh to EEh, never dual reads
// - mode byte with upper nibble equal to inverted lower nibble enters or keeps it
// - any equal upper/lower mode bit pair leaves the mode after the next select rise
// - an all-ones first byte in continuous mode forces exit to normal decoding
// - in continuous mode a new select starts directly with address clocks
// - continuous transaction: quad address, mode byte, 4 dummy clocks, data until select rises
// - burst command is C0h then one byte whose bit 4 enables (0) or disables (1) wrap
// - burst byte 00h to 03h gives 8/16/32/64 byte wrap, 1xh disables wrap
// - wrap is off after power-up until a burst command enables it
// - wrap setting holds until another burst command or a reset command
// - wrap applies to EBh and ECh reads in single-line and quad command modes
// - burst command takes 16 single-line clocks or 4 quad clocks, 8 or 2 for C0h and as many for its byte
// - boot read starts itself after power-on and reset command
// - boot read drives data from the start address after the selected delay
// - select rise ends the boot read and returns to normal command decoding
// - boot data goes out on one line when quad enable is 0, on four when 1
// - boot config bits 31..4 hold a 16-byte aligned start address, bit 3 reads one
// - boot config bit 0 low enables boot read, default high
// - boot config changes only by its write and erase commands and reads back
// - after a quad read opcode address, dummy and data use four lines
package flash_read_pkg;

  localparam logic [7:0] OP_QREAD = 8'hEB;
  localparam logic [7:0] OP_QREAD4B = 8'hEC;
  localparam logic [7:0] OP_QDTR = 8'hED;
  localparam logic [7:0] OP_QDTR4B = 8'hEE;
  localparam logic [7:0] OP_BURST = 8'hC0;
  localparam logic [7:0] OP_CFG_READ = 8'h16;
  localparam logic [7:0] OP_CFG_WRITE = 8'h17;
  localparam logic [7:0] OP_CFG_ERASE = 8'h18;
  localparam logic [7:0] MODE_FORCE_EXIT = 8'hFF;

  localparam logic [31:0] CFG_ERASED = 32'hFFFF_FFFF;
  localparam int CFG_ADDR_LSB = 4;
  localparam int CFG_UNUSED_BIT = 3;
  localparam int CFG_DLY_LSB = 1;
  localparam int CFG_DIS_BIT = 0;
  localparam int BURST_DIS_BIT = 4;

  localparam logic [5:0] DLY_SEL0 = 6'd7;
  localparam logic [5:0] DLY_SEL1 = 6'd9;
  localparam logic [5:0] DLY_SEL2 = 6'd11;
  localparam logic [5:0] DLY_SEL3 = 6'd13;

  localparam logic [5:0] CMD_CLK_SINGLE = 6'd8;
  localparam logic [5:0] CMD_CLK_QUAD = 6'd2;
  localparam logic [5:0] ADDR3_CLK = 6'd6;
  localparam logic [5:0] ADDR4_CLK = 6'd8;
  localparam logic [5:0] MODE_CLK = 6'd2;
  localparam logic [5:0] CFG_CLK_SINGLE = 6'd32;
  localparam logic [5:0] CFG_CLK_QUAD = 6'd8;
  localparam logic [3:0] BYTE_LEFT_SINGLE = 4'd7;
  localparam logic [3:0] BYTE_LEFT_QUAD = 4'd1;
  localparam logic [5:0] WRAP_BASE_MASK = 6'h07;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hF;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_CMD = 10'h002,
    ST_ADDR = 10'h004,
    ST_MODE = 10'h008,
    ST_DUMMY = 10'h010,
    ST_DATA = 10'h020,
    ST_BURST = 10'h040,
    ST_CFGW = 10'h080,
    ST_BOOT = 10'h100,
    ST_SKIP = 10'h200
  } state_t;

endpackage

// >>> rtl/flash_read_ext.sv
`timescale 1ns/1ps
module flash_read_ext
  import flash_read_pkg::*;
#(
  parameter logic [5:0] XIP_DUMMY = 6'd4,
  parameter logic [31:0] BOOT_CFG_INIT = CFG_ERASED
) (
  // clock and power-on reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // device state from the rest of the chip
  input wire logic quad_enable_bit_i,
  input wire logic quad_command_mode_i,
  input wire logic four_byte_addr_i,
  input wire logic busy_i,
  input wire logic reset_cmd_i,
  // array read port
  output logic [31:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  // status
  output logic xip_active_o,
  output logic wrap_enable_o,
  output logic [31:0] boot_read_config_o
);

  state_t state_r;
  logic [5:0] cnt_r;
  logic [31:0] sh_r;
  logic [7:0] op_r;
  logic sclk_q1, sclk_q2, sclk_q3;
  logic cs_q1, cs_q2, cs_q3;
  logic [3:0] io_q1, io_q2;
  logic xip_r, xip_exit_pend_r;
  logic wrap_en_r;
  logic [1:0] wrap_sel_r;
  logic [31:0] cfg_r;
  logic wr_pend_r, er_pend_r;
  logic boot_pend_r, boot_act_r;
  logic [31:0] rd_addr_r;
  logic rd_cfg_r, out_quad_r;
  logic [7:0] out_sh_r;
  logic [3:0] out_cnt_r;
  logic [3:0] io_o_r, io_oe_r;

  function automatic logic [5:0] boot_delay(input logic [1:0] sel);
    case (sel)
      2'b00: boot_delay = DLY_SEL0;
      2'b01: boot_delay = DLY_SEL1;
      2'b10: boot_delay = DLY_SEL2;
      default: boot_delay = DLY_SEL3;
    endcase
  endfunction

  function automatic logic is_quad_read(input logic [7:0] op);
    is_quad_read = (op == OP_QREAD) || (op == OP_QREAD4B) || (op == OP_QDTR) ||
                   (op == OP_QDTR4B);
  endfunction

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sclk_q1 <= 1'b0;
      sclk_q2 <= 1'b0;
      sclk_q3 <= 1'b0;
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
      cs_q3 <= 1'b1;
      io_q1 <= 4'h0;
      io_q2 <= 4'h0;
    end else begin
      sclk_q1 <= sclk_i;
      sclk_q2 <= sclk_q1;
      sclk_q3 <= sclk_q2;
      cs_q1 <= cs_n_i;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
      io_q1 <= io_i;
      io_q2 <= io_q1;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, step;
  assign sclk_rise = sclk_q2 & ~sclk_q3;
  assign sclk_fall = ~sclk_q2 & sclk_q3;
  assign cs_fall = ~cs_q2 & cs_q3;
  assign cs_rise = cs_q2 & ~cs_q3;
  assign step = sclk_rise & ~cs_rise & ~cs_fall & ~reset_cmd_i & ~cs_q2;

  logic in_quad, addr4;
  logic [31:0] sh_nxt;
  logic [5:0] cnt_inc, cmd_clks, addr_clks, cfg_clks, boot_dly;
  assign in_quad = (state_r inside {ST_ADDR, ST_MODE, ST_DUMMY}) ||
                   ((state_r inside {ST_CMD, ST_BURST, ST_CFGW}) && quad_command_mode_i);
  assign sh_nxt = in_quad ? {sh_r[27:0], io_q2} : {sh_r[30:0], io_q2[0]};
  assign cnt_inc = cnt_r + 6'd1;
  assign cmd_clks = quad_command_mode_i ? CMD_CLK_QUAD : CMD_CLK_SINGLE;
  assign cfg_clks = quad_command_mode_i ? CFG_CLK_QUAD : CFG_CLK_SINGLE;
  assign addr4 = four_byte_addr_i || (op_r == OP_QREAD4B) || (op_r == OP_QDTR4B);
  assign addr_clks = addr4 ? ADDR4_CLK : ADDR3_CLK;
  assign boot_dly = boot_delay(cfg_r[CFG_DLY_LSB +: 2]);

  logic cmd_done, addr_done, mode_done, burst_done, cfgw_done, boot_done, force_exit;
  logic mode_toggles, burst_dis_w;
  assign cmd_done = step && state_r == ST_CMD && cnt_inc == cmd_clks;
  assign addr_done = step && state_r == ST_ADDR && cnt_inc == addr_clks;
  assign mode_done = step && state_r == ST_MODE && cnt_inc == MODE_CLK;
  assign burst_done = step && state_r == ST_BURST && cnt_inc == cmd_clks;
  assign cfgw_done = step && state_r == ST_CFGW && cnt_inc == cfg_clks;
  assign boot_done = step && state_r == ST_BOOT && cnt_inc == boot_dly;
  assign force_exit = step && state_r == ST_ADDR && xip_r && cnt_inc == MODE_CLK &&
                      sh_nxt[7:0] == MODE_FORCE_EXIT;
  assign mode_toggles = sh_nxt[7:4] == ~sh_nxt[3:0];
  assign burst_dis_w = sh_nxt[BURST_DIS_BIT];

  // command sequencer
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || reset_cmd_i || cs_rise) begin
      state_r <= ST_IDLE;
      cnt_r <= 6'd0;
      sh_r <= 32'h0;
    end else if (cs_fall) begin
      cnt_r <= 6'd0;
      if (boot_pend_r) begin
        state_r <= ST_BOOT;
      end else if (xip_r) begin
        state_r <= ST_ADDR;
      end else begin
        state_r <= ST_CMD;
      end
    end else if (step) begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_inc;
      case (state_r)
        ST_CMD: begin
          if (cmd_done) begin
            cnt_r <= 6'd0;
            if (is_quad_read(sh_nxt[7:0])) begin
              state_r <= ST_ADDR;
            end else if (sh_nxt[7:0] == OP_BURST) begin
              state_r <= ST_BURST;
            end else if (sh_nxt[7:0] == OP_CFG_WRITE && !busy_i) begin
              state_r <= ST_CFGW;
            end else if (sh_nxt[7:0] == OP_CFG_READ) begin
              state_r <= ST_DATA;
            end else begin
              state_r <= ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          if (force_exit) begin
            state_r <= ST_SKIP;
          end else if (addr_done) begin
            state_r <= ST_MODE;
            cnt_r <= 6'd0;
          end
        end
        ST_MODE: begin
          if (mode_done) begin
            state_r <= ST_DUMMY;
            cnt_r <= 6'd0;
          end
        end
        ST_DUMMY: begin
          if (cnt_inc == XIP_DUMMY) begin
            state_r <= ST_DATA;
            cnt_r <= 6'd0;
          end
        end
        ST_BURST: begin
          if (burst_done) begin
            state_r <= ST_SKIP;
          end
        end
        ST_CFGW: begin
          if (cfgw_done) begin
            state_r <= ST_SKIP;
          end
        end
        ST_BOOT: begin
          if (boot_done) begin
            state_r <= ST_DATA;
            cnt_r <= 6'd0;
          end
        end
        ST_DATA, ST_SKIP, ST_IDLE: begin
          cnt_r <= 6'd0;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      op_r <= 8'h0;
    end else if (cmd_done) begin
      op_r <= sh_nxt[7:0];
    end
  end

  // continuous read mode
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || reset_cmd_i || force_exit) begin
      xip_r <= 1'b0;
      xip_exit_pend_r <= 1'b0;
    end else if (mode_done) begin
      if (mode_toggles) begin
        xip_r <= 1'b1;
        xip_exit_pend_r <= 1'b0;
      end else begin
        xip_exit_pend_r <= 1'b1;
      end
    end else if (cs_rise && xip_exit_pend_r) begin
      xip_r <= 1'b0;
      xip_exit_pend_r <= 1'b0;
    end
  end

  // wrap setting
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || reset_cmd_i) begin
      wrap_en_r <= 1'b0;
      wrap_sel_r <= 2'b00;
    end else if (burst_done) begin
      wrap_en_r <= ~burst_dis_w;
      if (!burst_dis_w) begin
        wrap_sel_r <= sh_nxt[1:0];
      end
    end
  end

  // boot configuration register, kept across reset commands
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cfg_r <= BOOT_CFG_INIT;
      wr_pend_r <= 1'b0;
      er_pend_r <= 1'b0;
    end else if (cs_rise) begin
      wr_pend_r <= 1'b0;
      er_pend_r <= 1'b0;
      if (wr_pend_r && !busy_i) begin
        cfg_r <= {sh_r[31:CFG_UNUSED_BIT + 1], 1'b1, sh_r[CFG_UNUSED_BIT - 1:0]};
      end else if (er_pend_r && !busy_i) begin
        cfg_r <= CFG_ERASED;
      end
    end else if (cs_fall || reset_cmd_i) begin
      wr_pend_r <= 1'b0;
      er_pend_r <= 1'b0;
    end else begin
      if (cfgw_done) begin
        wr_pend_r <= 1'b1;
      end
      if (cmd_done && sh_nxt[7:0] == OP_CFG_ERASE) begin
        er_pend_r <= 1'b1;
      end
    end
  end

  // boot read arming
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      boot_pend_r <= ~BOOT_CFG_INIT[CFG_DIS_BIT];
      boot_act_r <= 1'b0;
    end else if (reset_cmd_i) begin
      boot_pend_r <= ~cfg_r[CFG_DIS_BIT];
      boot_act_r <= 1'b0;
    end else if (cs_fall && boot_pend_r) begin
      boot_act_r <= 1'b1;
    end else if (cs_rise && boot_act_r) begin
      boot_pend_r <= 1'b0;
      boot_act_r <= 1'b0;
    end
  end

  logic ld_byte, wrap_act;
  logic [31:0] wrap_mask, rd_addr_nxt;
  assign ld_byte = sclk_fall && !cs_q2 && state_r == ST_DATA && out_cnt_r == 4'd0;
  assign wrap_act = wrap_en_r && !rd_cfg_r && !boot_act_r &&
                    (op_r == OP_QREAD || op_r == OP_QREAD4B);
  // depth 8 << sel: low mask 7, 15, 31 or 63
  assign wrap_mask = {26'h0, (WRAP_BASE_MASK << wrap_sel_r) | WRAP_BASE_MASK};
  assign rd_addr_nxt = wrap_act ? ((rd_addr_r & ~wrap_mask) | ((rd_addr_r + 32'd1) & wrap_mask))
                                : rd_addr_r + 32'd1;

  // read address and output width
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_addr_r <= 32'h0;
      rd_cfg_r <= 1'b0;
      out_quad_r <= 1'b0;
    end else if (cs_fall && boot_pend_r) begin
      rd_addr_r <= {cfg_r[31:CFG_ADDR_LSB], 4'h0};
      rd_cfg_r <= 1'b0;
      out_quad_r <= quad_enable_bit_i;
    end else if (addr_done) begin
      rd_addr_r <= addr4 ? sh_nxt : {8'h00, sh_nxt[23:0]};
      rd_cfg_r <= 1'b0;
      out_quad_r <= 1'b1;
    end else if (cmd_done && sh_nxt[7:0] == OP_CFG_READ) begin
      rd_addr_r <= 32'h0;
      rd_cfg_r <= 1'b1;
      out_quad_r <= quad_command_mode_i;
    end else if (ld_byte) begin
      rd_addr_r <= rd_addr_nxt;
    end
  end

  logic [7:0] byte_src;
  assign byte_src = rd_cfg_r ? cfg_r[8 * (3 - {30'h0, rd_addr_r[1:0]}) +: 8] : mem_data_i;

  // output shifter, driven on serial clock falling edges
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || reset_cmd_i || cs_q2 || state_r != ST_DATA) begin
      io_o_r <= 4'h0;
      io_oe_r <= 4'h0;
      out_sh_r <= 8'h0;
      out_cnt_r <= 4'd0;
    end else if (sclk_fall) begin
      if (out_cnt_r == 4'd0) begin
        if (out_quad_r) begin
          io_o_r <= byte_src[7:4];
          io_oe_r <= OE_QUAD;
          out_sh_r <= {byte_src[3:0], 4'h0};
          out_cnt_r <= BYTE_LEFT_QUAD;
        end else begin
          io_o_r <= {2'b00, byte_src[7], 1'b0};
          io_oe_r <= OE_SINGLE;
          out_sh_r <= {byte_src[6:0], 1'b0};
          out_cnt_r <= BYTE_LEFT_SINGLE;
        end
      end else begin
        io_o_r <= out_quad_r ? out_sh_r[7:4] : {2'b00, out_sh_r[7], 1'b0};
        out_sh_r <= out_quad_r ? {out_sh_r[3:0], 4'h0} : {out_sh_r[6:0], 1'b0};
        out_cnt_r <= out_cnt_r - 4'd1;
      end
    end
  end

  assign io_o = io_o_r;
  assign io_oe_o = io_oe_r;
  assign mem_addr_o = rd_addr_r;
  assign xip_active_o = xip_r;
  assign wrap_enable_o = wrap_en_r;
  assign boot_read_config_o = cfg_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_xip_open;
    cs_fall && xip_r && !boot_pend_r && !reset_cmd_i;
  endsequence
  sequence s_boot_open;
    cs_fall && boot_pend_r && !reset_cmd_i;
  endsequence
  sequence s_mode_hold;
    mode_done && !mode_toggles && !reset_cmd_i;
  endsequence

  a_xip_skip_cmd: assert property (s_xip_open |=> state_r == ST_ADDR)
    else $error("continuous read did not start with address");
  a_xip_enter: assert property (mode_done && mode_toggles && !is_quad_read(op_r) |-> 1'b0)
    else $error("continuous read entered from a non quad read");
  a_xip_keep: assert property (mode_done && mode_toggles |=>
      xip_r ##1 (xip_r || $past(reset_cmd_i)))
    else $error("toggling mode byte did not hold continuous read");
  a_xip_leave: assert property (s_mode_hold |=> xip_exit_pend_r && xip_r == $past(xip_r))
    else $error("continuous read exit ordering broken");
  a_xip_exit_cs: assert property (cs_rise && xip_exit_pend_r && !reset_cmd_i |=> !xip_r)
    else $error("continuous read not left after select rise");
  a_xip_force: assert property (force_exit |=> !xip_r && state_r == ST_SKIP)
    else $error("all-ones byte did not end continuous read");
  a_burst_decode: assert property (burst_done |=> wrap_en_r == !$past(burst_dis_w))
    else $error("burst byte decoded wrongly");
  a_wrap_reset: assert property (reset_cmd_i |=> !wrap_en_r)
    else $error("reset command kept wrap");
  a_wrap_block: assert property (ld_byte && wrap_act && !cs_rise |=>
      (rd_addr_r & ~wrap_mask) == ($past(rd_addr_r) & ~$past(wrap_mask)))
    else $error("wrapped read left its block");
  a_boot_start: assert property (s_boot_open |=> state_r == ST_BOOT && rd_addr_r[3:0] == 4'h0)
    else $error("boot read start wrong");
  a_boot_delay: assert property ($rose(state_r == ST_DATA) && boot_act_r |->
      $past(cnt_r) == boot_dly - 6'd1)
    else $error("boot delay count wrong");
  a_boot_lanes: assert property (boot_act_r && io_oe_r != 4'h0 |->
      io_oe_r == (out_quad_r ? OE_QUAD : OE_SINGLE))
    else $error("boot data on wrong lines");
  a_boot_done: assert property (cs_rise && boot_act_r && !reset_cmd_i |=> !boot_pend_r)
    else $error("boot read not ended by select rise");
  a_cfg_busy: assert property (busy_i && !cs_fall |=> cfg_r == $past(cfg_r))
    else $error("boot config changed while busy");

endmodule

// >>> verification/flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model (
  // pacing clock
  input wire logic core_clk_i,
  // serial pins
  input wire logic [3:0] io_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
    io_oe_o = 4'h0;
  end

  // half of a 160 ns serial period, well under any boot clock limit
  task automatic half();
    repeat (4) @(negedge core_clk_i);
  endtask

  task automatic sel();
    @(negedge core_clk_i);
    cs_n_o = 1'b0;
  endtask

  task automatic desel();
    half();
    io_oe_o = 4'h0;
    cs_n_o = 1'b1;
    repeat (6) @(negedge core_clk_i);
  endtask

  // mode 0: drive after the falling edge, sample on the rising edge, msb first
  task automatic xfer(input logic [31:0] v, input int nclk, input int w, input bit drv,
                      output logic [31:0] r);
    logic [31:0] sh;
    sh = v << (32 - nclk * w);
    r = '0;
    io_oe_o = drv ? ((w == 4) ? 4'hF : 4'h1) : 4'h0;
    for (int k = 0; k < nclk; k++) begin
      if (w == 4) begin
        io_o = sh[31:28];
      end else begin
        io_o = {~io_o[3:1], sh[31]};
      end
      sh = sh << w;
      half();
      sclk_o = 1'b1;
      r = (w == 4) ? {r[27:0], io_i} : {r[30:0], io_i[1]};
      half();
      sclk_o = 1'b0;
    end
  endtask
endmodule

// >>> verification/flash_read_ext_tb.sv
`timescale 1ns/1ps
module flash_read_ext_tb;
  import flash_read_pkg::*;
  localparam logic [31:0] BOOT_INIT = 32'h0001_234A;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic qe = 1'b0, qcm = 1'b0, busy = 1'b0, rst_cmd = 1'b0, four_b = 1'b0;
  logic sclk, cs_n, xip, wrap;
  logic [3:0] h_io, h_oe, d_io, d_oe, io_w;
  logic [31:0] mem_addr, cfg, r, v, a;
  logic [7:0] mem_data, code, m;
  logic [7:0] ops [5] = '{8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hBB};
  logic [7:0] modes [4] = '{8'hA5, 8'h5A, 8'hF0, 8'h0F};
  integer seed = 34494;
  int fail_count = 0;
  int cmp_count = 0;

  function automatic logic [7:0] mem_f(input logic [15:0] x);
    return x[7:0] ^ {x[11:8], x[15:12]} ^ 8'h3C;
  endfunction

  function automatic logic [31:0] exp_byte(input logic [31:0] x, input int i, input int depth);
    logic [31:0] mk;
    logic [31:0] b;
    mk = 32'(depth - 1);
    b = (x & ~mk) | ((x + 32'(i)) & mk);
    return {24'h0, mem_f(b[15:0])};
  endfunction

  always #10 core_clk = ~core_clk;
  // a released line shows the inverse of the host's last value
  assign io_w = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & ~h_io);
  assign mem_data = mem_f(mem_addr[15:0]);

  flash_read_ext #(.BOOT_CFG_INIT(BOOT_INIT)) i_dut (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .sclk_i(sclk), .cs_n_i(cs_n),
    .io_i(io_w), .io_o(d_io), .io_oe_o(d_oe), .quad_enable_bit_i(qe),
    .quad_command_mode_i(qcm), .four_byte_addr_i(four_b), .busy_i(busy),
    .reset_cmd_i(rst_cmd), .mem_addr_o(mem_addr), .mem_data_i(mem_data),
    .xip_active_o(xip), .wrap_enable_o(wrap), .boot_read_config_o(cfg));

  flash_host_model i_host (.core_clk_i(core_clk), .io_i(io_w), .sclk_o(sclk),
    .cs_n_o(cs_n), .io_o(h_io), .io_oe_o(h_oe));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    i_host.xfer({24'h0, op}, qcm ? 2 : 8, qcm ? 4 : 1, 1'b1, r);
  endtask

  task automatic pulse_rst();
    @(negedge core_clk);
    rst_cmd = 1'b1;
    @(negedge core_clk);
    rst_cmd = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic qread(input logic [7:0] op, input bit skip, input logic [31:0] x,
                       input int nab, input logic [7:0] md, input int n, input int depth);
    i_host.sel();
    if (!skip) begin
      cmd(op);
    end
    i_host.xfer(x, nab, 4, 1'b1, r);
    i_host.xfer({24'h0, md}, 2, 4, 1'b1, r);
    i_host.xfer(32'h0, 4, 4, 1'b0, r);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(32'h0, 2, 4, 1'b0, r);
      check("read data", r, exp_byte(x, i, depth));
    end
    if (n > 0) begin
      check("quad lanes", {28'h0, d_oe}, {28'h0, OE_QUAD});
    end
    i_host.desel();
  endtask

  task automatic burst(input logic [7:0] c);
    i_host.sel();
    cmd(OP_BURST);
    i_host.xfer({24'h0, c}, qcm ? 2 : 8, qcm ? 4 : 1, 1'b1, r);
    i_host.desel();
  endtask

  initial begin
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    check("config reset", cfg, BOOT_INIT);
    check("wrap reset", {31'h0, wrap}, 32'h0);
    repeat (4) @(negedge core_clk);
    // boot read on one line at power-on, on four lines after a reset command
    for (int q = 0; q < 2; q++) begin
      qe = q[0];
      i_host.sel();
      i_host.xfer(32'h0, 9, 1, 1'b0, r);
      i_host.xfer(32'h0, q ? 4 : 8, q ? 4 : 1, 1'b0, r);
      v = q ? {16'h0, mem_f(16'h2340), mem_f(16'h2341)} : {24'h0, mem_f(16'h2340)};
      check("boot data", r, v);
      check("boot lanes", {28'h0, d_oe}, q ? {28'h0, OE_QUAD} : {28'h0, OE_SINGLE});
      i_host.desel();
      if (q == 0) begin
        pulse_rst();
      end
    end
    i_host.sel();
    cmd(OP_CFG_READ);
    i_host.xfer(32'h0, 32, 1, 1'b0, r);
    i_host.desel();
    check("config read", r, BOOT_INIT);
    for (int b = 1; b >= 0; b--) begin
      v = $random(seed);
      busy = b[0];
      i_host.sel();
      cmd(OP_CFG_WRITE);
      i_host.xfer(v, 32, 1, 1'b1, r);
      i_host.desel();
      busy = 1'b0;
      check("config write", cfg, b ? BOOT_INIT : (v | 32'h8));
    end
    i_host.sel();
    cmd(OP_CFG_ERASE);
    i_host.desel();
    check("config erase", cfg, CFG_ERASED);
    // every wrap depth, alternating single-line and quad command modes, then disabled
    for (int j = 0; j < 5; j++) begin
      qcm = j[0];
      code = (j == 4) ? (8'h10 | 8'($random(seed) & 15)) : 8'(j);
      burst(code);
      check("wrap flag", {31'h0, wrap}, {31'h0, j < 4});
      a = $random(seed) & 32'hFFFFFF;
      qread(OP_QREAD, 1'b0, a, 6, 8'h00, (j < 4) ? (8 << j) + 3 : 5,
            (j < 4) ? 8 << j : 0);
    end
    burst(8'h02);
    pulse_rst();
    check("wrap cleared", {31'h0, wrap}, 32'h0);
    qcm = 1'b0;
    // continuous mode for each quad read, never for the dual read
    for (int k = 0; k < 5; k++) begin
      m = modes[$random(seed) & 3];
      a = $random(seed) & 32'hFFFFFF;
      qread(ops[k], 1'b0, a, ops[k][0] ? 6 : 8, m, (k < 4) ? 2 : 0, 0);
      check("continuous flag", {31'h0, xip}, {31'h0, k < 4});
      i_host.sel();
      i_host.xfer(32'hFF, 2, 4, 1'b1, r);
      i_host.desel();
      check("forced exit", {31'h0, xip}, 32'h0);
    end
    // keep the first address byte off all ones, which would force an exit
    a[23] = 1'b0;
    qread(OP_QREAD, 1'b0, a, 6, 8'hA5, 2, 0);
    qread(OP_QREAD, 1'b1, a ^ 32'h5555, 6, 8'h5A, 2, 0);
    check("mode kept", {31'h0, xip}, 32'h1);
    qread(OP_QREAD, 1'b1, a ^ 32'hAA00, 6, 8'h00, 3, 0);
    check("mode left", {31'h0, xip}, 32'h0);
    four_b = 1'b1;
    qread(OP_QREAD, 1'b0, a, 8, 8'h00, 2, 0);
    four_b = 1'b0;
    conclude();
  end

  initial begin
    #1_000_000;
    fail_count++;
    conclude();
  end
endmodule
